/* protection_pkg.sv */
// Purpose: constants for the excitation protection and alarm block
// Assumes: 20 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   thresholds are raw metered codes unless stated otherwise
package protection_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SEC_CYCLES     = CLK_HZ;
  localparam int unsigned GOV_DELAY_MS   = 750;
  localparam int unsigned GOV_CYCLES     = CLK_HZ / 1000 * GOV_DELAY_MS;
  localparam int unsigned FOV_SECONDS    = 15;

  localparam int unsigned ADDR_W         = 6;
  localparam logic [5:0]  ADDR_OEL_LEVEL = 6'h00;
  localparam logic [5:0]  ADDR_OEL_DELAY = 6'h04;
  localparam logic [5:0]  ADDR_FOV_LEVEL = 6'h08;
  localparam logic [5:0]  ADDR_LOS_DELAY = 6'h0c;
  localparam logic [5:0]  ADDR_GOV_PCT   = 6'h10;
  localparam logic [5:0]  ADDR_STATUS    = 6'h14;
  localparam logic [5:0]  ADDR_IRQ_MASK  = 6'h18;
  localparam logic [5:0]  ADDR_IRQ_STAT  = 6'h1c;

  localparam int unsigned OEL_W          = 13;
  localparam logic [12:0] OEL_MAX        = 13'h1d4c;
  localparam logic [3:0]  OEL_DELAY_MAX  = 4'ha;
  localparam int unsigned FOV_W          = 16;
  localparam logic [4:0]  LOS_DELAY_MAX  = 5'h19;
  localparam logic [6:0]  GOV_PCT_MIN    = 7'h69;
  localparam logic [6:0]  GOV_PCT_MAX    = 7'h78;
  localparam logic [6:0]  GOV_PCT_RST    = 7'h69;
  localparam logic [15:0] FOV_RST        = 16'hffff;
  localparam logic [12:0] OEL_RST        = 13'h1d4c;

  localparam int unsigned EV_OEL         = 0;
  localparam int unsigned EV_FOV         = 1;
  localparam int unsigned EV_LOS         = 2;
  localparam int unsigned EV_GOV         = 3;
  localparam int unsigned EV_ALARM       = 4;
  localparam int unsigned EV_N           = 5;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

/* excitation_protection_alarm.sv */
// Purpose: excitation protection thresholds, delay timers, alarm contact
// Assumes: metered inputs are synchronous codes updated by the meter front end
// Notes:   field current in mA, generator voltage as percent of nominal
// Operation
// - overexcitation current threshold 0 to 7.5 A in 0.001 A steps
// - field current above threshold lights overexcitation lamp and starts delay
// - alarm contact closes after overexcitation delay 0 to 10 s, 1 s steps
// - field voltage above its threshold also lights overexcitation lamp
// - field overvoltage lasting over 15 s closes the alarm contact
// - sensing loss waits 0 to 25 s then asserts the shutdown action
// - generator overvoltage threshold 105 to 120 percent, 1 percent steps
// - generator overvoltage lights its lamp, alarm closes after 0.75 s
`timescale 1ns/1ps
`default_nettype none
module excitation_protection_alarm (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] field_current_ma,
  input  wire logic [15:0] field_voltage,
  input  wire logic [7:0]  gen_voltage_pct,
  input  wire logic        sensing_loss,
  output logic             overexcitation_led,
  output logic             gen_overvoltage_led,
  output logic             alarm_contact_terminals,
  output logic             sensing_loss_action,
  output logic             irq,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // settings
  logic [12:0] oel_level_reg;
  logic [3:0]  oel_delay_reg;
  logic [15:0] fov_level_reg;
  logic [4:0]  los_delay_reg;
  logic [6:0]  gov_pct_reg;
  logic [4:0]  irq_mask_reg;
  logic [4:0]  irq_stat_reg;

  // one second timebase
  logic [24:0] sec_cnt_reg;
  wire         sec_tick = (sec_cnt_reg == 25'(protection_pkg::SEC_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || sec_tick) begin
      sec_cnt_reg <= 25'h0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 25'h1;
    end
  end

  // conditions
  wire oel_cond = (field_current_ma > {3'h0, oel_level_reg});
  wire fov_cond = (field_voltage > fov_level_reg);
  wire gov_cond = (gen_voltage_pct > {1'h0, gov_pct_reg});
  wire los_cond = sensing_loss;

  // second-resolution timers and a cycle-count gov timer, cleared when condition drops
  logic [4:0] oel_sec_reg;
  logic [4:0] fov_sec_reg;
  logic [4:0] los_sec_reg;
  logic [23:0] gov_cnt_reg;
  logic oel_done_reg;
  logic fov_done_reg;
  logic los_done_reg;
  logic gov_done_reg;

  // expiry compares kept outside the timer processes
  wire oel_expired = (oel_sec_reg >= {1'h0, oel_delay_reg});
  wire fov_expired = (fov_sec_reg > 5'(protection_pkg::FOV_SECONDS));
  wire los_expired = (los_sec_reg >= los_delay_reg);
  wire gov_expired = (gov_cnt_reg >= 24'(protection_pkg::GOV_CYCLES - 1));

  // the first timer tick may land early by up to one second; the delay
  // counts whole ticks so the figure is met within one timebase period
  always_ff @(posedge aclk) begin
    if (!aresetn || !oel_cond) begin
      oel_sec_reg  <= 5'h0;
      oel_done_reg <= 1'b0;
    end else begin
      if (oel_expired) begin
        oel_done_reg <= 1'b1;
      end else if (sec_tick) begin
        oel_sec_reg <= oel_sec_reg + 5'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !fov_cond) begin
      fov_sec_reg  <= 5'h0;
      fov_done_reg <= 1'b0;
    end else begin
      if (fov_expired) begin
        fov_done_reg <= 1'b1;
      end else if (sec_tick) begin
        fov_sec_reg <= fov_sec_reg + 5'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !los_cond) begin
      los_sec_reg  <= 5'h0;
      los_done_reg <= 1'b0;
    end else begin
      if (los_expired) begin
        los_done_reg <= 1'b1;
      end else if (sec_tick) begin
        los_sec_reg <= los_sec_reg + 5'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !gov_cond) begin
      gov_cnt_reg  <= 24'h0;
      gov_done_reg <= 1'b0;
    end else begin
      if (gov_expired) begin
        gov_done_reg <= 1'b1;
      end else begin
        gov_cnt_reg <= gov_cnt_reg + 24'h1;
      end
    end
  end

  // alarm follows its causes, it is not latched
  // sensing loss has its own action pin and leaves the alarm alone
  wire alarm_next = oel_done_reg | fov_done_reg | gov_done_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overexcitation_led      <= 1'b0;
      gen_overvoltage_led     <= 1'b0;
      alarm_contact_terminals <= 1'b0;
      sensing_loss_action     <= 1'b0;
    end else begin
      overexcitation_led      <= oel_cond | fov_cond;
      gen_overvoltage_led     <= gov_cond;
      alarm_contact_terminals <= alarm_next;
      sensing_loss_action     <= los_done_reg;
    end
  end

  // events and interrupt
  logic [4:0] ev_set;
  always_comb begin
    ev_set                           = 5'h0;
    ev_set[protection_pkg::EV_OEL]   = oel_cond;
    ev_set[protection_pkg::EV_FOV]   = fov_cond;
    ev_set[protection_pkg::EV_LOS]   = los_done_reg;
    ev_set[protection_pkg::EV_GOV]   = gov_cond;
    ev_set[protection_pkg::EV_ALARM] = alarm_next & ~alarm_contact_terminals;
  end

  // registered so the pin cannot glitch while mask and status change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // axi4-lite write path
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [5:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  // aw and w are parked until both are in; nothing taken while b waits
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_hold_reg || aw_fire;
  wire w_have  = w_hold_reg || w_fire;
  wire [5:0]  wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  wire        wr_go   = aw_have && w_have && !bvalid_reg;
  wire        wr_lo   = wr_go && wr_strb[0];
  wire        wr_hi   = wr_go && wr_strb[1];

  // read-only status and unmapped offsets answer with slverr
  wire wr_known = (wr_addr == protection_pkg::ADDR_OEL_LEVEL)
               || (wr_addr == protection_pkg::ADDR_OEL_DELAY)
               || (wr_addr == protection_pkg::ADDR_FOV_LEVEL)
               || (wr_addr == protection_pkg::ADDR_LOS_DELAY)
               || (wr_addr == protection_pkg::ADDR_GOV_PCT)
               || (wr_addr == protection_pkg::ADDR_IRQ_MASK)
               || (wr_addr == protection_pkg::ADDR_IRQ_STAT);

  // data bits above each field are dropped, then out-of-range field values are clamped to the nearest legal value
  wire [12:0] oel_wr = {(wr_hi ? wr_data[12:8] : oel_level_reg[12:8]),
                        (wr_lo ? wr_data[7:0] : oel_level_reg[7:0])};
  wire [12:0] oel_cl = (oel_wr > protection_pkg::OEL_MAX)
                       ? protection_pkg::OEL_MAX : oel_wr;
  wire [3:0]  od_cl  = (wr_data[3:0] > protection_pkg::OEL_DELAY_MAX)
                       ? protection_pkg::OEL_DELAY_MAX : wr_data[3:0];
  wire [4:0]  ld_cl  = (wr_data[4:0] > protection_pkg::LOS_DELAY_MAX)
                       ? protection_pkg::LOS_DELAY_MAX : wr_data[4:0];
  wire [6:0]  gp_cl  = (wr_data[6:0] < protection_pkg::GOV_PCT_MIN)
                       ? protection_pkg::GOV_PCT_MIN
                       : (wr_data[6:0] > protection_pkg::GOV_PCT_MAX)
                       ? protection_pkg::GOV_PCT_MAX : wr_data[6:0];
  wire [4:0]  clr_bits = (wr_lo && wr_addr == protection_pkg::ADDR_IRQ_STAT)
                         ? wr_data[4:0] : 5'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 6'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= protection_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) awaddr_reg <= s_axi_awaddr;
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? protection_pkg::RESP_OKAY
                                : protection_pkg::RESP_SLVERR;
      end else begin
        aw_hold_reg <= aw_have;
        w_hold_reg  <= w_have;
        if (bvalid_reg && s_axi_bready) bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oel_level_reg <= protection_pkg::OEL_RST;
      oel_delay_reg <= 4'h0;
      fov_level_reg <= protection_pkg::FOV_RST;
      los_delay_reg <= 5'h0;
      gov_pct_reg   <= protection_pkg::GOV_PCT_RST;
      irq_mask_reg  <= 5'h0;
    end else if (wr_go) begin
      if (wr_addr == protection_pkg::ADDR_OEL_LEVEL && (wr_lo || wr_hi))
        oel_level_reg <= oel_cl;
      if (wr_lo && wr_addr == protection_pkg::ADDR_OEL_DELAY)
        oel_delay_reg <= od_cl;
      if (wr_addr == protection_pkg::ADDR_FOV_LEVEL) begin
        if (wr_lo) fov_level_reg[7:0]  <= wr_data[7:0];
        if (wr_hi) fov_level_reg[15:8] <= wr_data[15:8];
      end
      if (wr_lo && wr_addr == protection_pkg::ADDR_LOS_DELAY)
        los_delay_reg <= ld_cl;
      if (wr_lo && wr_addr == protection_pkg::ADDR_GOV_PCT)
        gov_pct_reg <= gp_cl;
      if (wr_lo && wr_addr == protection_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= wr_data[4:0];
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 5'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr_bits) | ev_set;
    end
  end

  // axi4-lite read path
  logic [31:0] live;
  always_comb begin
    live                           = 32'h0;
    live[protection_pkg::EV_OEL]   = oel_cond;
    live[protection_pkg::EV_FOV]   = fov_cond;
    live[protection_pkg::EV_LOS]   = sensing_loss_action;
    live[protection_pkg::EV_GOV]   = gen_overvoltage_led;
    live[protection_pkg::EV_ALARM] = alarm_contact_terminals;
  end
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      protection_pkg::ADDR_OEL_LEVEL: rd_mux = {19'h0, oel_level_reg};
      protection_pkg::ADDR_OEL_DELAY: rd_mux = {28'h0, oel_delay_reg};
      protection_pkg::ADDR_FOV_LEVEL: rd_mux = {16'h0, fov_level_reg};
      protection_pkg::ADDR_LOS_DELAY: rd_mux = {27'h0, los_delay_reg};
      protection_pkg::ADDR_GOV_PCT:   rd_mux = {25'h0, gov_pct_reg};
      protection_pkg::ADDR_STATUS:    rd_mux = live;
      protection_pkg::ADDR_IRQ_MASK:  rd_mux = {27'h0, irq_mask_reg};
      protection_pkg::ADDR_IRQ_STAT:  rd_mux = {27'h0, irq_stat_reg};
      default:                        rd_ok  = 1'b0;
    endcase
  end

  // one read in flight; the reply stands until rready
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= protection_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? protection_pkg::RESP_OKAY
                            : protection_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* protection_asserts.sv */
// Purpose: port-level checks for the excitation protection block
// Assumes: one clock, synchronous active-low reset
// Notes:   thresholds are internal, so checks lean on their clamp limits
`timescale 1ns/1ps
`default_nettype none
module protection_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] field_current_ma,
  input wire logic [7:0]  gen_voltage_pct,
  input wire logic        sensing_loss,
  input wire logic        overexcitation_led,
  input wire logic        gen_overvoltage_led,
  input wire logic        alarm_contact_terminals,
  input wire logic        sensing_loss_action,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_arready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_oel_led;
    field_current_ma > 16'd7500 |=> overexcitation_led;
  endproperty
  a_oel_led: assert property (p_oel_led)
    else $error("overexcitation lamp dark above top limit");
  property p_gov_off;
    gen_voltage_pct <= 8'd105 |=> !gen_overvoltage_led;
  endproperty
  a_gov_off: assert property (p_gov_off)
    else $error("overvoltage lamp lit below lowest limit");
  property p_gov_on;
    gen_voltage_pct > 8'd120 |=> gen_overvoltage_led;
  endproperty
  a_gov_on: assert property (p_gov_on)
    else $error("overvoltage lamp dark above top limit");
  property p_alarm_cause;
    $rose(alarm_contact_terminals) |->
      overexcitation_led || gen_overvoltage_led;
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm closed with no lamp lit");
  property p_alarm_clear;
    (!overexcitation_led && !gen_overvoltage_led) [*3] |->
      !alarm_contact_terminals;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm held after conditions cleared");
  property p_los_clear;
    !sensing_loss [*3] |-> !sensing_loss_action;
  endproperty
  a_los_clear: assert property (p_los_clear)
    else $error("sensing loss action without sensing loss");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while data pending");
endmodule
bind excitation_protection_alarm protection_asserts u_chk (.aclk, .aresetn,
  .field_current_ma, .gen_voltage_pct, .sensing_loss, .overexcitation_led,
  .gen_overvoltage_led, .alarm_contact_terminals, .sensing_loss_action,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_arready);
`default_nettype wire

/* generator_field.sv */
// Purpose: behavioural generator field and sensing front end
// Assumes: meter codes refresh once per aclk edge
// Notes:   levels follow the bench's requests one cycle later
`timescale 1ns/1ps
`default_nettype none
module generator_field (
  input  wire logic        aclk,
  input  wire logic [15:0] cur_req,
  input  wire logic [15:0] volt_req,
  input  wire logic [7:0]  pct_req,
  input  wire logic        loss_req,
  output var  logic [15:0] field_current_ma,
  output var  logic [15:0] field_voltage,
  output var  logic [7:0]  gen_voltage_pct,
  output var  logic        sensing_loss
);
  initial field_current_ma = '0;
  initial field_voltage = '0;
  initial gen_voltage_pct = '0;
  initial sensing_loss = 1'b0;
  always @(posedge aclk) begin
    field_current_ma <= cur_req;
    field_voltage <= volt_req;
    gen_voltage_pct <= pct_req;
    sensing_loss <= loss_req;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the excitation protection block
// Assumes: 20 MHz aclk, AXI4-Lite master driven on rising edges
// Notes:   second timers are too long to run; zero delays are used
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 0, aresetn = 0, loss_req = 0;
  logic [15:0] cur_req = 0, volt_req = 0;
  logic [7:0] pct_req = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire logic [15:0] field_current_ma, field_voltage;
  wire logic [7:0] gen_voltage_pct;
  wire logic sensing_loss, overexcitation_led, gen_overvoltage_led, irq;
  wire logic alarm_contact_terminals, sensing_loss_action, s_axi_awready;
  wire logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  integer n_mismatch = 0, tests_run = 0, cyc = 0, g;
  logic [34:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [5:0] ca[8] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h0c, 6'h0c, 6'h10, 6'h10};
  logic [31:0] cw[8] = '{'hffff, 'h3e8, 'h1f, 'h0, 'hff, 'h0, 'h7f, 'h10};
  logic [31:0] ce[8] = '{'h1d4c, 'h3e8, 'ha, 'h0, 'h19, 'h0, 'h78, 'h69};
  logic [31:0] rv[8] = '{'h1d4c, 0, 'hffff, 0, 'h69, 0, 0, 0};
  localparam logic [1:0] OK = protection_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = protection_pkg::RESP_SLVERR;
  localparam logic [5:0] ST = protection_pkg::ADDR_STATUS;
  localparam logic [5:0] IS = protection_pkg::ADDR_IRQ_STAT;
  localparam logic [5:0] IM = protection_pkg::ADDR_IRQ_MASK;
  excitation_protection_alarm u_dut (.*);
  generator_field u_field (.*);
  always #25 aclk = ~aclk;
  task automatic check(input logic [34:0] seen, input logic [34:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end while (pa || pw || !s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r, input logic i);
    logic pa;
    pa = 1;
    exp_r.push_back({i, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (pa && s_axi_arready) begin
        pa = 0;
        s_axi_arvalid <= 1'b0;
      end
    end while (pa || !s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // zero-second timers settle within a few cycles
  task automatic meter(input logic [15:0] c, v, input logic [7:0] p,
                       input logic l, input logic [3:0] e);
    cur_req <= c;
    volt_req <= v;
    pct_req <= p;
    loss_req <= l;
    repeat (12) @(posedge aclk);
    check({31'h0, overexcitation_led, gen_overvoltage_led,
           alarm_contact_terminals, sensing_loss_action}, {31'h0, e});
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      check({irq, s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check({33'h0, s_axi_bresp}, {33'h0, exp_b.pop_front()});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h9260bba3));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 8; k++) rd(6'(k * 4), rv[k], OK, 1'b0);
    rd(6'h20, 32'h0, ERR, 1'b0);
    wr(6'h20, 32'h5, ERR);
    for (int k = 0; k < 8; k++) begin
      wr(ca[k], cw[k], OK);
      rd(ca[k], ce[k], OK, 1'b0);
    end
    g = 105 + $urandom % 16;
    wr(protection_pkg::ADDR_GOV_PCT, 32'(g), OK);
    rd(protection_pkg::ADDR_GOV_PCT, 32'(g), OK, 1'b0);
    wr(IM, 32'h1f, OK);
    meter(16'd9000, 16'h0, 8'h0, 1'b0, 4'ha);
    rd(ST, 32'h11, OK, 1'b1);
    meter(16'd1000, 16'h0, 8'h0, 1'b0, 4'h0);
    rd(ST, 32'h0, OK, 1'b1);
    rd(IS, 32'h11, OK, 1'b1);
    wr(IS, 32'h1f, OK);
    s_axi_wstrb <= 4'h1;
    wr(protection_pkg::ADDR_FOV_LEVEL, 32'h1200, OK);
    rd(protection_pkg::ADDR_FOV_LEVEL, 32'hff00, OK, 1'b0);
    s_axi_wstrb <= 4'hf;
    wr(protection_pkg::ADDR_FOV_LEVEL, 32'h100, OK);
    meter(16'h0, 16'h101, 8'h0, 1'b0, 4'h8);
    rd(ST, 32'h02, OK, 1'b1);
    meter(16'h0, 16'h100, 8'h0, 1'b0, 4'h0);
    rd(IS, 32'h02, OK, 1'b1);
    wr(IS, 32'h1f, OK);
    wr(protection_pkg::ADDR_GOV_PCT, 32'h6e, OK);
    meter(16'h0, 16'h0, 8'd130, 1'b0, 4'h4);
    rd(ST, 32'h08, OK, 1'b1);
    meter(16'h0, 16'h0, 8'd110, 1'b0, 4'h0);
    rd(ST, 32'h0, OK, 1'b1);
    rd(IS, 32'h08, OK, 1'b1);
    wr(IS, 32'h1f, OK);
    wr(IM, 32'h0, OK);
    meter(16'h0, 16'h0, 8'h0, 1'b1, 4'h1);
    rd(ST, 32'h04, OK, 1'b0);
    wr(IM, 32'h04, OK);
    rd(IS, 32'h04, OK, 1'b1);
    meter(16'h0, 16'h0, 8'h0, 1'b0, 4'h0);
    wr(ST, 32'h1f, ERR);
    wr(IS, 32'h04, OK);
    rd(ST, 32'h0, OK, 1'b0);
    rd(IS, 32'h0, OK, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
